// *** src/srdp_defs.svh ***
// constants of the read data port
`ifndef SRDP_DEFS_SVH
`define SRDP_DEFS_SVH
`define SRDP_DATA_W 36
`define SRDP_ADDR_W 19
`define SRDP_DEPTH_LOG2 6
`define SRDP_RESET_DATA 36'h000000000
`endif

// *** src/srdp_pkg.sv ***
// types of the read data port
`include "srdp_defs.svh"
package srdp_pkg;
    typedef struct packed {
        logic [`SRDP_ADDR_W-1:0] addr;
        logic [7:0] tag;
    } srdp_req_t;
    typedef struct packed {
        logic [`SRDP_DATA_W-1:0] word1;
        logic [`SRDP_DATA_W-1:0] word0;
    } srdp_burst_t;
    typedef enum logic [1:0] {
        SRDP_OST_IDLE = 2'b01,
        SRDP_OST_DRIVE = 2'b10
    } srdp_ostate_t;
endpackage

// *** src/srdp_mem.sv ***
// memory array, one burst (two words) per address, registered read
`timescale 1ns/1ns
module srdp_mem
    import srdp_pkg::*;
#(
    parameter int AW = `SRDP_DEPTH_LOG2
) (
    input wire logic i_clk,
    input wire logic i_rd,
    input wire logic [AW-1:0] i_raddr,
    output srdp_burst_t o_rdata
);
    srdp_burst_t mem [0:(1<<AW)-1];
    srdp_burst_t rdata_r;
    localparam int DW = $bits(srdp_burst_t) / 2;
    // preset pattern stands in for written data, as the write port is
    // outside this block: word0 is twice the index, word1 the next odd
    initial begin
        for (int i = 0; i < (1<<AW); i++) begin
            mem[i].word0 = DW'(2 * i);
            mem[i].word1 = DW'(2 * i + 1);
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rd) begin
            rdata_r <= mem[i_raddr];
        end
    end
    assign o_rdata = rdata_r;
endmodule // srdp_mem

// *** src/srdp_read_port.sv ***
// read data port of a synchronous double-rate burst memory
//
// What this block does
// - read data appears only on the dedicated data output pins
// - data launched on output clock pair, or input pair in single mode
// - outputs float whenever no burst is in progress on the output side
// - select is sampled only on rising edge of positive input clock
// - select sampled low starts a read at the captured address
// - select high mid-read: outstanding burst still finishes first
// - after deselect and burst end, float after next output clock edge
// - each read returns exactly two words in sequential order
// - output clock pair together times data out of the device
// - all synchronous inputs captured on positive input clock rise
// - address sampled with select, ignored when port deselected
`timescale 1ns/1ns
module srdp_read_port
    import srdp_pkg::*;
#(
    parameter int DW = `SRDP_DATA_W,
    parameter int AW = `SRDP_ADDR_W,
    parameter int MW = `SRDP_DEPTH_LOG2
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_read_port_select_n,
    input wire logic [AW-1:0] i_addr,
    input wire logic i_single_clock_mode,
    input wire logic i_out_clk,
    input wire logic i_out_clk_n,
    output logic [DW-1:0] o_q,
    output logic o_q_oe_n
);
    // ----------------------------------------------------------------
    // clock mode pin
    // ----------------------------------------------------------------
    // the mode pin is a board strap; two flops keep a slow edge on it
    // from reaching the clock select half settled; change it only
    // while the port is idle
    logic mode_m_r;
    logic mode_s_r;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_m_r <= 1'b0;
            mode_s_r <= 1'b0;
        end else begin
            mode_m_r <= i_single_clock_mode;
            mode_s_r <= mode_m_r;
        end
    end

    // ----------------------------------------------------------------
    // input side, on the positive input clock
    // ----------------------------------------------------------------
    // i_clk is the positive input clock itself, so select and address
    // are synchronous to it and are registered directly
    logic sel_r;
    logic [AW-1:0] addr_r;
    srdp_burst_t rdata;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sel_r <= 1'b0;
        end else begin
            sel_r <= ~i_read_port_select_n;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            addr_r <= '0;
        end else if (!i_read_port_select_n) begin
            addr_r <= i_addr;
        end
    end

    // ----------------------------------------------------------------
    // memory array and burst hold
    // ----------------------------------------------------------------
    srdp_mem #(
        .AW(MW)
    ) u_mem (
        .i_clk(i_clk),
        .i_rd(sel_r),
        .i_raddr(addr_r[MW-1:0]),
        .o_rdata(rdata)
    );

    // burst held stable for the output domain until the next read
    srdp_burst_t hold_r;
    logic hold_ld_r;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hold_ld_r <= 1'b0;
        end else begin
            hold_ld_r <= sel_r;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hold_r <= '0;
        end else if (hold_ld_r) begin
            hold_r <= rdata;
        end
    end
    logic hold_tgl_r;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hold_tgl_r <= 1'b0;
        end else if (hold_ld_r) begin
            hold_tgl_r <= ~hold_tgl_r;
        end
    end

    // ----------------------------------------------------------------
    // output side, on the output clock pair
    // ----------------------------------------------------------------
    // in single clock mode the input clock and its inverse take over;
    // the strap only switches while idle, so a stray edge is harmless
    logic oclk;
    logic oclk_n;
    assign oclk = mode_s_r ? i_clk : i_out_clk;
    assign oclk_n = mode_s_r ? ~i_clk : i_out_clk_n;

    // ----------------------------------------------------------------
    // crossing to the output side
    // ----------------------------------------------------------------
    // reset is crossed as a level; floating after a burst needs one
    // more positive output edge, so the output clock must keep running
    logic rst_m_r;
    logic rst_s_r;
    always_ff @(posedge oclk) begin
        rst_m_r <= i_srst;
        rst_s_r <= rst_m_r;
    end

    logic tgl_m_r;
    logic tgl_s_r;
    logic tgl_d_r;
    always_ff @(posedge oclk) begin
        if (rst_s_r) begin
            tgl_m_r <= 1'b0;
            tgl_s_r <= 1'b0;
            tgl_d_r <= 1'b0;
        end else begin
            tgl_m_r <= hold_tgl_r;
            tgl_s_r <= tgl_m_r;
            tgl_d_r <= tgl_s_r;
        end
    end

    logic new_burst;
    assign new_burst = tgl_s_r ^ tgl_d_r;

    // ----------------------------------------------------------------
    // output sequencing
    // ----------------------------------------------------------------
    // both words are copied on the positive output edge; hold_r is
    // stable then, and the negative edge reads only this local copy,
    // so no word crosses domains on an edge that might catch it moving
    logic [DW-1:0] q_p_r;
    logic [DW-1:0] q_w1_r;
    always_ff @(posedge oclk) begin
        if (rst_s_r) begin
            q_p_r <= '0;
            q_w1_r <= '0;
        end else if (new_burst) begin
            q_p_r <= hold_r.word0;
            q_w1_r <= hold_r.word1;
        end
    end

    // one output period of drive per burst; a burst once seen always
    // completes, whatever the select does meanwhile; bit 0 of the
    // state code is the active-low drive enable itself
    srdp_ostate_t ost_r;
    always_ff @(posedge oclk) begin
        if (rst_s_r) begin
            ost_r <= SRDP_OST_IDLE;
        end else begin
            unique case (ost_r)
                SRDP_OST_IDLE: begin
                    if (new_burst) begin
                        ost_r <= SRDP_OST_DRIVE;
                    end
                end
                SRDP_OST_DRIVE: begin
                    if (!new_burst) begin
                        ost_r <= SRDP_OST_IDLE;
                    end
                end
                default: begin
                    ost_r <= SRDP_OST_IDLE;
                end
            endcase
        end
    end

    // float whenever idle, straight from the state flop
    assign o_q_oe_n = ost_r[0];

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    // second word on the negative output edge that follows the first;
    // it stands through the low phase and the enable drops at the next
    // positive edge
    logic [DW-1:0] q_n_r;
    always_ff @(posedge oclk_n) begin
        if (rst_s_r) begin
            q_n_r <= '0;
        end else begin
            q_n_r <= q_w1_r;
        end
    end

    // pin mux: high phase shows word0, low phase word1; the mux is the
    // price of two data edges per clock on one set of pins
    always_comb begin
        o_q = oclk ? q_p_r : q_n_r;
    end
endmodule // srdp_read_port

// *** verif/srdp_read_port_monitor.sv ***
// assertions on the read data port
`timescale 1ns/1ns
module srdp_mon #(parameter int DW = 36) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_read_port_select_n,
    input wire logic i_single_clock_mode,
    input wire logic i_out_clk,
    input wire logic i_out_clk_n,
    input wire logic [DW-1:0] o_q,
    input wire logic o_q_oe_n
);
    // the data clock pair follows the mode pin, as at the pins
    wire ock;
    wire ock_n;
    assign ock = i_single_clock_mode ? i_clk : i_out_clk;
    assign ock_n = i_single_clock_mode ? ~i_clk : i_out_clk_n;
    default clocking @(posedge ock); endclocking
    default disable iff (i_srst);
    // preset words: the first of a burst is even, the second odd
    property p_word0;
        @(posedge ock_n) !o_q_oe_n |-> o_q[0] == 1'b0;
    endproperty
    a_word0: assert property (p_word0)
        else $error("first word not even");
    property p_word1;
        !o_q_oe_n |-> o_q[0] == 1'b1;
    endproperty
    a_word1: assert property (p_word1)
        else $error("second word not odd");
    property p_one_burst;
        $fell(o_q_oe_n) |=> o_q_oe_n;
    endproperty
    a_one_burst: assert property (p_one_burst)
        else $error("drive longer than one burst");
    property p_float;
        $rose(o_q_oe_n) |=> o_q_oe_n;
    endproperty
    a_float: assert property (p_float)
        else $error("drive resumed");
    property p_start;
        $fell(i_read_port_select_n) |-> ##[2:24] $fell(o_q_oe_n);
    endproperty
    a_start: assert property (p_start)
        else $error("no burst");
    property p_finish;
        $rose(i_read_port_select_n) |-> ##[1:24] $fell(o_q_oe_n);
    endproperty
    a_finish: assert property (p_finish)
        else $error("burst dropped");
    // eight idle samples leave room for any pending burst to end
    property p_idle;
        @(posedge i_clk) i_read_port_select_n [*8] |-> o_q_oe_n;
    endproperty
    a_idle: assert property (p_idle)
        else $error("drive while idle");
    property p_rst;
        @(posedge i_clk) disable iff (1'b0) i_srst [*4] |-> o_q_oe_n;
    endproperty
    a_rst: assert property (p_rst)
        else $error("drive in reset");
endmodule // srdp_mon
bind srdp_read_port srdp_mon #(.DW(DW)) mon_u (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_read_port_select_n(i_read_port_select_n),
    .i_single_clock_mode(i_single_clock_mode),
    .i_out_clk(i_out_clk),
    .i_out_clk_n(i_out_clk_n),
    .o_q(o_q),
    .o_q_oe_n(o_q_oe_n)
);

// *** verif/srdp_ctrl_model.sv ***
// controller side: free-running output clock pair
`timescale 1ns/1ns
module srdp_ctrl_model (
    output logic o_out_clk,
    output logic o_out_clk_n
);
    // 15 ns period on a 1 ns grid, so the phases are 8 and 7
    always begin
        o_out_clk = 1'b1;
        #8;
        o_out_clk = 1'b0;
        #7;
    end
    assign o_out_clk_n = ~o_out_clk;
endmodule // srdp_ctrl_model

// *** verif/srdp_read_port_test.sv ***
// self-checking bench of the read data port
`timescale 1ns/1ns
module srdp_read_port_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic sel_n = 1'b1;
    logic [18:0] addr = 19'h00000;
    logic oclk, oclk_n, oe_n;
    logic [35:0] q;
    logic mode = 1'b0;
    logic sclk;
    logic [35:0] exp_w0 = 36'h0;
    int fail_count = 0, tests_run = 0, beats = 0, cyc = 0;
    always #20 clk = ~clk;
    srdp_ctrl_model model_u (.o_out_clk(oclk), .o_out_clk_n(oclk_n));
    srdp_read_port dut_u (.i_clk(clk), .i_srst(srst),
        .i_read_port_select_n(sel_n), .i_addr(addr),
        .i_single_clock_mode(mode), .i_out_clk(oclk),
        .i_out_clk_n(oclk_n), .o_q(q), .o_q_oe_n(oe_n));
    task chk(input string n, input logic [35:0] s, input logic [35:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task stop_test();
        $display("checks %0d fails %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // sample 3 ns after each edge, clear of the launching edge; high phase word0
    assign sclk = mode ? clk : oclk;
    always @(sclk) begin
        #3;
        if (oe_n === 1'b0) begin
            beats++;
            chk("q", q, sclk ? exp_w0 : exp_w0 + 36'h1);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            stop_test();
        end
    end
    // n reads two cycles apart; the address flips while deselected
    task t_read(input int n, input logic [18:0] a);
        beats = 0;
        exp_w0 = {29'h0, a[5:0], 1'b0};
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            sel_n <= 1'b0;
            addr <= a;
            @(posedge clk);
            sel_n <= 1'b1;
            addr <= ~a;
        end
        repeat (12) @(posedge clk);
        chk("beats", 36'(beats), 36'(2 * n));
        chk("oe_n", {35'h0, oe_n}, 36'h1);
        $display("reads %0d at %h done", n, a);
    endtask
    // single clock mode: the input clock times the data as well
    task t_single(input logic [18:0] a);
        mode <= 1'b1;
        repeat (4) @(posedge clk);
        beats = 0;
        exp_w0 = {29'h0, a[5:0], 1'b0};
        for (int i = 0; i < 2; i++) begin
            sel_n <= 1'b0;
            addr <= a;
            @(posedge clk);
            sel_n <= 1'b1;
            addr <= ~a;
            repeat (3) @(posedge clk);
        end
        repeat (12) @(posedge clk);
        chk("single beats", 36'(beats), 36'h4);
        chk("single oe_n", {35'h0, oe_n}, 36'h1);
        mode <= 1'b0;
        repeat (4) @(posedge clk);
        $display("single clock reads at %h done", a);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        t_read(0, 19'h00000);
        t_read(1, 19'h00000);
        t_read(3, 19'h7FFFF);
        t_single(19'h00005);
        stop_test();
    end
endmodule // srdp_read_port_test
